//--- hpbs_pkg.sv
package hpbs_pkg;
  // ****************************************
  // host register selects
  // ****************************************
  localparam logic [1:0] HPBS_SEL_CTRL = 2'h0;
  localparam logic [1:0] HPBS_SEL_ADDR_INC = 2'h1;
  localparam logic [1:0] HPBS_SEL_ADDR = 2'h2;
  localparam logic [1:0] HPBS_SEL_DATA = 2'h3;
  // ****************************************
  // strap positions and defaults
  // ****************************************
  localparam int HPBS_POS_ENDIAN = 8;
  localparam int HPBS_POS_LANE = 12;
  localparam int HPBS_POS_BOOT = 3;
  localparam logic HPBS_RST_ENDIAN = 1'h1;
  localparam logic HPBS_RST_LANE = 1'h1;
  localparam logic [1:0] HPBS_RST_BOOT = 2'h1;
  localparam logic [1:0] HPBS_BOOT_HOST = 2'h0;
  localparam logic [1:0] HPBS_BOOT_ROM8 = 2'h1;
  localparam logic [1:0] HPBS_BOOT_ROM16 = 2'h2;
  localparam logic [1:0] HPBS_BOOT_ROM32 = 2'h3;
  localparam logic [1:0] HPBS_LANE_LOW = 2'h0;
  localparam logic [1:0] HPBS_LANE_HIGH = 2'h3;
  localparam logic [15:0] HPBS_RST_WORD = 16'h0000;
endpackage : hpbs_pkg

//--- hpbs_strap.sv
`timescale 1ns/100ps
`default_nettype none
module hpbs_strap (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // strap pins
  input wire logic [15:0] pins_in,
  // decoded modes
  output logic little_endian,
  output logic lane_fix,
  output logic [1:0] boot_mode
);
  import hpbs_pkg::*;
  logic rst_seen;
  // ****************************************
  // capture at release
  // ****************************************
  // straps are taken on the first edge after release, never under reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rst_seen <= 1'b1;
    end else begin
      rst_seen <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      little_endian <= HPBS_RST_ENDIAN;
      lane_fix <= HPBS_RST_LANE;
      boot_mode <= HPBS_RST_BOOT;
    end else if (rst_seen) begin
      little_endian <= pins_in[HPBS_POS_ENDIAN];
      lane_fix <= pins_in[HPBS_POS_LANE];
      boot_mode <= pins_in[HPBS_POS_BOOT +: 2];
    end
  end
  // a capture shows one edge later, so hold is judged from the next edge
  AST_STRAP_HOLD: assert property (
    @(posedge clk) disable iff (!rstn)
    !rst_seen |=> $stable(boot_mode) && $stable(little_endian) &&
    $stable(lane_fix))
    else $error("strap changed outside reset release");
  AST_STRAP_TAKE: assert property (
    @(posedge clk) disable iff (!rstn)
    rst_seen |=> boot_mode == $past(pins_in[HPBS_POS_BOOT +: 2]))
    else $error("boot strap not captured");
endmodule : hpbs_strap
`default_nettype wire

//--- hpbs_host_port.sv
`timescale 1ns/100ps
`default_nettype none
module hpbs_host_port (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host control inputs, active low strobes
  input wire logic host_reg_select_hi,
  input wire logic host_reg_select_lo,
  input wire logic halfword_order_select,
  input wire logic host_rw_select,
  input wire logic host_addr_strobe_n,
  input wire logic host_chip_select_n,
  input wire logic host_data_strobe_a_n,
  input wire logic host_data_strobe_b_n,
  // host data bus, three signals
  input wire logic [15:0] host_data_bus_in,
  output logic [15:0] host_data_bus_out,
  output logic host_data_bus_oe,
  // core side
  input wire logic irq_req,
  input wire logic [31:0] core_rd_word,
  output logic host_irq_out,
  output logic [1:0] access_reg,
  output logic access_second_half,
  output logic access_write,
  output logic access_strobe,
  output logic [15:0] access_wdata,
  // strap outcomes
  output logic little_endian,
  output logic [1:0] narrow_lane,
  output logic [1:0] boot_mode,
  output logic boot_from_host,
  output logic [1:0] rom_width_code
);
  import hpbs_pkg::*;
  typedef enum logic [2:0] {
    HPBS_IDLE = 3'b001,
    HPBS_ACT = 3'b010,
    HPBS_DONE = 3'b100
  } hpbs_state_t;
  hpbs_state_t state;
  logic strb;
  logic [1:0] lat_sel;
  logic lat_hw;
  logic s_le;
  logic s_lane;
  logic [1:0] s_boot;
  logic [1:0] cur_sel;
  logic cur_hw;
  logic as_prev;
  logic lat_use;

  // selects are latched on the address strobe, else used live
  function automatic logic [1:0] hpbs_lane(input logic fix, input logic le);
    hpbs_lane = (!fix || le) ? HPBS_LANE_LOW : HPBS_LANE_HIGH;
  endfunction : hpbs_lane

  // ****************************************
  // strap capture
  // ****************************************
  hpbs_strap u_strap (
    .clk(clk),
    .rstn(rstn),
    .pins_in(host_data_bus_in),
    .little_endian(s_le),
    .lane_fix(s_lane),
    .boot_mode(s_boot)
  );
  always_ff @(posedge clk) begin
    if (!rstn) begin
      little_endian <= HPBS_RST_ENDIAN;
      narrow_lane <= HPBS_LANE_HIGH;
      boot_mode <= HPBS_RST_BOOT;
      boot_from_host <= 1'b0;
      rom_width_code <= HPBS_RST_BOOT;
    end else begin
      little_endian <= s_le;
      narrow_lane <= hpbs_lane(s_lane, s_le);
      boot_mode <= s_boot;
      boot_from_host <= (s_boot == HPBS_BOOT_HOST);
      rom_width_code <= s_boot;
    end
  end

  // ****************************************
  // host access decode
  // ****************************************
  assign strb = !host_chip_select_n &&
                (!host_data_strobe_a_n ^ !host_data_strobe_b_n);
  // strobe history idles high, so leaving reset gives no false fall
  always_ff @(posedge clk) begin
    if (!rstn) begin
      as_prev <= 1'b1;
    end else begin
      as_prev <= host_addr_strobe_n;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lat_sel <= HPBS_SEL_CTRL;
      lat_hw <= 1'b0;
    end else if (!host_addr_strobe_n && as_prev) begin
      lat_sel <= {host_reg_select_hi, host_reg_select_lo};
      lat_hw <= halfword_order_select;
    end
  end
  // live selects until the strobe has fallen; tied high keeps them live
  assign lat_use = !host_addr_strobe_n && !as_prev;
  assign cur_sel = lat_use ? lat_sel :
                   {host_reg_select_hi, host_reg_select_lo};
  assign cur_hw = lat_use ? lat_hw : halfword_order_select;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= HPBS_IDLE;
    end else begin
      case (state)
        HPBS_IDLE: if (strb) state <= HPBS_ACT;
        HPBS_ACT: state <= HPBS_DONE;
        HPBS_DONE: if (!strb) state <= HPBS_IDLE;
        default: state <= HPBS_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      access_reg <= HPBS_SEL_CTRL;
      access_second_half <= 1'b0;
      access_write <= 1'b0;
      access_strobe <= 1'b0;
      access_wdata <= HPBS_RST_WORD;
    end else begin
      access_strobe <= (state == HPBS_IDLE) && strb;
      if ((state == HPBS_IDLE) && strb) begin
        access_reg <= cur_sel;
        access_second_half <= cur_hw;
        access_write <= !host_rw_select;
        access_wdata <= host_data_bus_in;
      end
    end
  end

  // ****************************************
  // data bus drive and interrupt
  // ****************************************
  // reads drive the bus from the edge after the strobe comes in until the edge after it ends, never during reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      host_data_bus_oe <= 1'b0;
      host_data_bus_out <= HPBS_RST_WORD;
    end else begin
      host_data_bus_oe <= strb && host_rw_select;
      host_data_bus_out <= cur_hw ? core_rd_word[31:16]
                                  : core_rd_word[15:0];
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      host_irq_out <= 1'b0;
    end else begin
      host_irq_out <= irq_req;
    end
  end

  AST_NO_DRIVE_ON_WRITE: assert property (
    @(posedge clk) disable iff (!rstn)
    !$past(host_rw_select) |-> !host_data_bus_oe)
    else $error("bus driven during write");
  AST_DRIVE_ON_READ: assert property (
    @(posedge clk) disable iff (!rstn)
    strb && host_rw_select |=> host_data_bus_oe)
    else $error("bus not driven on read");
  AST_IRQ: assert property (
    @(posedge clk) disable iff (!rstn)
    irq_req |=> host_irq_out)
    else $error("interrupt not forwarded");
  AST_ONE_STROBE: assert property (
    @(posedge clk) disable iff (!rstn)
    access_strobe |=> !access_strobe)
    else $error("access strobe longer than one cycle");
  AST_WRITE_DIR: assert property (
    @(posedge clk) disable iff (!rstn)
    access_strobe |-> access_write == !$past(host_rw_select))
    else $error("write direction wrong");
  AST_LANE: assert property (
    @(posedge clk) disable iff (!rstn)
    s_lane && !s_le |=> narrow_lane == HPBS_LANE_HIGH)
    else $error("big endian lane wrong");
  AST_LANE_LOW: assert property (
    @(posedge clk) disable iff (!rstn)
    !s_lane |=> narrow_lane == HPBS_LANE_LOW)
    else $error("fixed lane not low");
  AST_BOOT_HOST: assert property (
    @(posedge clk) disable iff (!rstn)
    s_boot == HPBS_BOOT_HOST |=> boot_from_host)
    else $error("host boot not flagged");

  // ****************************************
  // read walk and select latch
  // ****************************************
  sequence hpbs_read_taken;
    (state == HPBS_IDLE) && strb && host_rw_select;
  endsequence
  sequence hpbs_read_answer;
    access_strobe && host_data_bus_oe;
  endsequence
  AST_READ_WALK: assert property (
    @(posedge clk) disable iff (!rstn)
    hpbs_read_taken |=> hpbs_read_answer)
    else $error("read answer not one cycle after the strobe");
  AST_LATCH_TAKE: assert property (
    @(posedge clk) disable iff (!rstn)
    !host_addr_strobe_n && as_prev |=>
    lat_sel[1] == $past(host_reg_select_hi) &&
    lat_sel[0] == $past(host_reg_select_lo))
    else $error("selects not latched at strobe fall");
  AST_LATCH_HOLD: assert property (
    @(posedge clk) disable iff (!rstn)
    lat_use |=> $stable(lat_sel) && $stable(lat_hw))
    else $error("latched selects moved while strobe low");
endmodule : hpbs_host_port
`default_nettype wire

//--- hpbs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module hpbs_host_model (
  // clock and resistors
  input wire logic clk,
  input wire logic [15:0] pull,
  // device drive
  input wire logic bus_oe,
  input wire logic [15:0] bus_out,
  // host pins
  output logic sel_hi,
  output logic sel_lo,
  output logic hw,
  output logic rw,
  output logic as_n,
  output logic cs_n,
  output logic ds_a_n,
  output logic ds_b_n,
  output wire logic [15:0] bus
);
  logic drv = 1'b0;
  logic [15:0] dout = 16'h0000;
  // host never drives during reset, so straps come from resistors
  assign bus = bus_oe ? bus_out : (drv ? dout : pull);
  initial begin
    {sel_hi, sel_lo, hw, rw} = 4'h0;
    {as_n, cs_n, ds_a_n, ds_b_n} = 4'hf;
  end
  // entered at a rising edge; holds everything until the answer edge
  // lat holds the address strobe low and moves the selects once latched
  task automatic xfer(input logic [1:0] s, input logic h, r, both, lat,
      input logic [15:0] wd, output logic [15:0] rd);
    int n;
    n = 0;
    {sel_hi, sel_lo} <= s;
    hw <= h;
    if (lat) begin
      as_n <= 1'b0;
      @(posedge clk);
      {sel_hi, sel_lo} <= ~s;
      hw <= !h;
      @(posedge clk);
    end
    rw <= r;
    {cs_n, ds_a_n, ds_b_n} <= {2'h0, !both};
    drv <= !r;
    dout <= wd;
    @(posedge clk);
    while (r && bus_oe !== 1'b1 && n < 6) begin
      @(posedge clk);
      n++;
    end
    if (!r) repeat (2) @(posedge clk);
    rd = bus;
    {as_n, cs_n, ds_a_n, ds_b_n} <= 4'hf;
    drv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : xfer
endmodule : hpbs_host_model
`default_nettype wire

//--- hpbs_host_port_test.sv
`timescale 1ns/100ps
`default_nettype none
module hpbs_host_port_test;
  import hpbs_pkg::*;
  logic clk, rstn, irq_req, hi, lo, hw, rw, as_n, cs_n, da_n, db_n;
  logic [15:0] pull, out, rd, wd;
  wire logic [15:0] bus;
  logic oe, irq, astb, ahalf, awr, le, bfh;
  logic [1:0] areg, lane, boot, rwc;
  logic [15:0] awd;
  logic [31:0] core = 32'ha5c3_3c5a;
  int err_total, checked, nstb;
  hpbs_host_port u_hpbs_host_port (.clk(clk), .rstn(rstn),
    .host_reg_select_hi(hi), .host_reg_select_lo(lo),
    .halfword_order_select(hw), .host_rw_select(rw),
    .host_addr_strobe_n(as_n), .host_chip_select_n(cs_n),
    .host_data_strobe_a_n(da_n), .host_data_strobe_b_n(db_n),
    .host_data_bus_in(bus), .host_data_bus_out(out),
    .host_data_bus_oe(oe), .irq_req(irq_req), .core_rd_word(core),
    .host_irq_out(irq), .access_reg(areg), .access_second_half(ahalf),
    .access_write(awr), .access_strobe(astb), .access_wdata(awd),
    .little_endian(le), .narrow_lane(lane), .boot_mode(boot),
    .boot_from_host(bfh), .rom_width_code(rwc));
  hpbs_host_model u_hpbs_host_model (.clk(clk), .pull(pull),
    .bus_oe(oe), .bus_out(out), .sel_hi(hi), .sel_lo(lo), .hw(hw),
    .rw(rw), .as_n(as_n), .cs_n(cs_n), .ds_a_n(da_n), .ds_b_n(db_n),
    .bus(bus));
  // ****************************************
  // clock, counters, checks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  always @(posedge clk) if (astb === 1'b1) nstb <= nstb + 1;
  task automatic chk(input string nm, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_straps();
    logic [1:0] en;
    for (int i = 0; i < 16; i++) begin
      rstn <= 1'b0;
      pull <= 16'hffef & ~16'h1118 | {3'h0, i[1], 3'h0, i[0], 3'h0,
        i[3:2], 3'h0};
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      en = (i[1] && !i[0]) ? HPBS_LANE_HIGH : HPBS_LANE_LOW;
      for (int k = 0; k < 2; k++) begin
        chk("endian", 16'(i[0]), 16'(le));
        chk("lane", 16'(en), 16'(lane));
        chk("boot", 16'(i[3:2]), 16'(boot));
        chk("host boot", 16'(i[3:2] == 2'h0), 16'(bfh));
        chk("rom width", 16'(i[3:2]), 16'(rwc));
        pull <= ~pull;
        repeat (3) @(posedge clk);
      end
    end
    $display("test straps done");
  endtask : t_straps
  task automatic t_access();
    for (int s = 0; s < 8; s++) begin
      wd = 16'h1234 * (s + 1);
      u_hpbs_host_model.xfer(s[2:1], s[0], 1'b0, 1'b0, 1'b0, wd, rd);
      chk("wdata", wd, awd);
      chk("fields", 16'({s[2:1], s[0], 1'b1}),
        16'({areg, ahalf, awr}));
      u_hpbs_host_model.xfer(s[2:1], s[0], 1'b1, 1'b0, 1'b0, wd, rd);
      chk("rdata", s[0] ? core[31:16] : core[15:0], rd);
      chk("rfields", 16'({s[2:1], 1'b0}), 16'({areg, awr}));
      chk("oe idle", 16'h0000, 16'(oe));
    end
    u_hpbs_host_model.xfer(2'h2, 1'b1, 1'b0, 1'b0, 1'b1, wd, rd);
    chk("latched fields", 16'h000b, 16'({areg, ahalf, awr}));
    u_hpbs_host_model.xfer(2'h1, 1'b1, 1'b1, 1'b0, 1'b1, wd, rd);
    chk("latched rdata", core[31:16], rd);
    chk("latched reg", 16'h0001, 16'(areg));
    chk("strobes", 16'h0012, 16'(nstb));
    u_hpbs_host_model.xfer(2'h3, 1'b0, 1'b1, 1'b1, 1'b0, wd, rd);
    chk("both strobes", pull, rd);
    chk("no strobe", 16'h0012, 16'(nstb));
    $display("test access done");
  endtask : t_access
  task automatic t_irq();
    for (int v = 1; v >= 0; v--) begin
      irq_req <= v[0];
      @(posedge clk);
      @(posedge clk);
      chk("irq", 16'(v[0]), 16'(irq));
    end
    $display("test irq done");
  endtask : t_irq
  initial begin
    {err_total, checked, nstb} = '0;
    rstn = 1'b0;
    irq_req = 1'b0;
    pull = 16'hffef;
    repeat (20) @(posedge clk);
    #1 chk("rst modes", 16'({HPBS_RST_ENDIAN, HPBS_LANE_HIGH, HPBS_RST_BOOT,
      3'h0}), 16'({le, lane, boot, oe, irq, bfh}));
    @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("default boot", 16'(HPBS_RST_BOOT), 16'(boot));
    @(posedge clk);
    t_straps();
    t_access();
    t_irq();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule : hpbs_host_port_test
`default_nettype wire
